// ==== src/rlc_level_loop.sv ====
// rlc_level_loop: automatic level control of the record amplifiers with peak limiter,
// gain ceiling, zero-cross gated updates and a quiet gate.
// Assumes an outside slot decoder presents control register reads and writes as strobes,
// and that the record converter delivers one stereo sample per valid strobe.
`timescale 1ns/1ps

// Function
// - Compare converter peak with target and steer record gain to hold level.
// - Select field: off, right only, left only, or both channels.
// - Both channels: use larger peak, apply the same gain to both amplifiers.
// - One channel: steer that amplifier, other keeps its programmed volume.
// - Target from -28.5 dBFS to -6 dBFS in 1.5 dB steps, reset 1011.
// - Wait the hold delay after peak drops below target before raising gain.
// - Hold only delays rises; gain falls start without delay.
// - Rise time 24 ms doubling per code, clamped at code 1010, reset 0011.
// - Fall time 6 ms doubling per code, clamped at code 1010, reset 0010.
// - Ceiling caps loop gain from -12 dB to +30 dB; no effect when off.
// - Loop zero-cross bit overrides record bit; gated or immediate gain changes.
// - Zero-cross timeout of 2^14 to 2^17 clock periods, reset 11.
// - Above 87.5% full scale, lower gain at the fastest fall rate.
// - Limiter is always active while the loop is enabled.
// - Quiet gate engages below threshold plus gain plus boost; holds gain.
// - Gate type set: also mute the converter output while engaged.
// - Gate threshold from -76.5 dBFS to -30 dBFS in 1.5 dB steps.
// - Gate works only with loop on, on the loop's channels.
// - Writes to the record gain register are ignored while the loop runs.
// - Loop drives amplifiers in the extended range, 0.75 dB steps.
module rlc_level_loop
  import rlc_pkg::*;
#(
  parameter int unsigned HOLD_BASE_CYC = rlc_pkg::HOLD_BASE_CYC,
  parameter int unsigned DECAY_STEP_CYC = rlc_pkg::DECAY_STEP_CYC,
  parameter int unsigned ATTACK_STEP_CYC = rlc_pkg::ATTACK_STEP_CYC,
  parameter int unsigned ZERO_CROSSING_WAIT_LIMIT_MIN_CYC = rlc_pkg::ZERO_CROSSING_WAIT_LIMIT_MIN_CYC
) (
  // clock and reset
  input wire logic CORE_CLK,
  input wire logic RESETN,
  // control register port
  input wire logic REG_WR,
  input wire logic REG_RD,
  input wire logic [6:0] REG_ADDR,
  input wire logic [15:0] REG_WDATA,
  output logic [15:0] REG_RDATA,
  // record converter samples and mic boost state
  input wire logic ADC_VALID,
  input wire logic [15:0] ADC_LEFT,
  input wire logic [15:0] ADC_RIGHT,
  input wire logic MIC_BOOST,
  // record amplifier and converter mute controls
  output rlc_pkg::rlc_pga_t PGA_LEFT,
  output rlc_pkg::rlc_pga_t PGA_RIGHT,
  output logic GATE_ENGAGED
);

  rlc_timing_t tim_q;
  rlc_gate_t gate_q;
  rlc_rgain_t rgain_q;
  rlc_state_t st_q;
  rlc_state_t st_d;
  logic [5:0] loop_gain_q;
  logic [5:0] loop_gain_d;
  logic [5:0] app_gain_q;
  logic [31:0] step_cnt_q;
  logic [31:0] step_cnt_d;
  logic [31:0] hold_cnt_q;
  logic [31:0] zc_cnt_q;

  // register decode
  logic sel_gain;
  logic sel_tim;
  logic sel_gate;
  logic [15:0] rd_mux;

  // loop decode
  logic loop_on;
  logic ctl_l;
  logic ctl_r;
  logic [6:0] peak_log;
  logic over_limit;
  logic zero_cross;
  logic [6:0] target_log;
  logic [5:0] ceil_code;
  logic above;
  logic below;
  logic gate_on;
  logic [9:0] gate_rhs;
  logic tick;
  logic hold_done;
  logic pending;
  logic apply;
  logic [31:0] hold_len;
  logic [31:0] zc_len;

  // step interval of one ramp code; codes past 1010 stay at the longest ramp
  function automatic logic [31:0] ramp_len(input int unsigned base, input logic [3:0] code);
    logic [3:0] sh;
    sh = (code > RAMP_CODE_MAX) ? RAMP_CODE_MAX : code;
    ramp_len = 32'(base) << sh;
  endfunction

  // address decode of the control port
  always_comb begin
    sel_gain = 1'b0;
    sel_tim = 1'b0;
    sel_gate = 1'b0;
    if (REG_ADDR == ADDR_RECORD_GAIN) begin
      sel_gain = 1'b1;
    end else if (REG_ADDR == ADDR_LOOP_TIMING) begin
      sel_tim = 1'b1;
    end else if (REG_ADDR == ADDR_LOOP_GATE) begin
      sel_gate = 1'b1;
    end
  end

  // read data; unmapped addresses read as zero
  assign rd_mux = sel_gain ? rgain_q :
                  sel_tim ? tim_q :
                  sel_gate ? gate_q : 16'h0000;

  // channel selection: bit 1 steers left, bit 0 steers right
  assign loop_on = gate_q.level_loop_channel_select != SEL_OFF;
  assign ctl_l = gate_q.level_loop_channel_select[1];
  assign ctl_r = gate_q.level_loop_channel_select[0];

  // peak of the controlled channels; larger of both in two-channel mode
  rlc_level_meter u_meter (
    .clk(CORE_CLK),
    .rst_n(RESETN),
    .sample_valid(ADC_VALID),
    .sample_left(ADC_LEFT),
    .sample_right(ADC_RIGHT),
    .use_left(ctl_l),
    .use_right(ctl_r),
    .clear(tick),
    .peak_log_q(peak_log),
    .over_limit_q(over_limit),
    .zero_cross_q(zero_cross)
  );

  // level comparisons, all on the 0.75 dB log scale
  assign target_log = TARGET_BASE_LOG + {2'b00, tim_q.level_loop_target, 1'b0};
  assign ceil_code = CEIL_BASE_CODE + {gate_q.loop_gain_ceiling, 3'b000};
  assign above = (peak_log > target_log) || over_limit;
  assign below = peak_log < target_log;
  assign gate_rhs = GATE_BASE_LOG + {4'h0, gate_q.quiet_gate_threshold, 1'b0}
    + {4'h0, app_gain_q} + (MIC_BOOST ? BOOST_LOG : 10'h000) - GAIN_ZERO_DB_CODE;
  // the sum may go negative with low gain, so compare signed
  assign gate_on = loop_on && gate_q.quiet_gate_enable
    && ($signed({3'b000, peak_log}) < $signed(gate_rhs));

  // a rising level cuts short the current step so falls start at once
  assign tick = loop_on && ((step_cnt_q == 32'h0000_0000) || (above && st_q != ST_FALL));
  assign hold_done = hold_cnt_q == 32'h0000_0000;
  assign hold_len = (tim_q.gain_rise_hold_delay == 4'h0) ? 32'h0000_0000 :
    32'(HOLD_BASE_CYC) << (tim_q.gain_rise_hold_delay - 4'h1);
  assign zc_len = 32'(ZERO_CROSSING_WAIT_LIMIT_MIN_CYC) << gate_q.zero_crossing_wait_limit;

  // step decision: one code per tick, fall before ceiling before rise
  always_comb begin
    st_d = st_q;
    loop_gain_d = loop_gain_q;
    step_cnt_d = (step_cnt_q == 32'h0000_0000) ? step_cnt_q : step_cnt_q - 32'h0000_0001;
    if (!loop_on) begin
      st_d = ST_TRACK;
      loop_gain_d = ctl_l ? rgain_q.record_volume_left : rgain_q.record_volume_right;
      step_cnt_d = 32'h0000_0000;
      if (gate_q.level_loop_channel_select == SEL_OFF) begin
        loop_gain_d = rgain_q.record_volume_left;
      end
    end else if (tick) begin
      if (above || loop_gain_q > ceil_code) begin
        st_d = ST_FALL;
        if (loop_gain_q != 6'h00) loop_gain_d = loop_gain_q - 6'h01;
        step_cnt_d = over_limit ? 32'(ATTACK_STEP_CYC) :
          ramp_len(ATTACK_STEP_CYC, tim_q.gain_fall_time);
      end else if (below && !gate_on) begin
        if (hold_done) begin
          st_d = ST_RISE;
          if (loop_gain_q < ceil_code) loop_gain_d = loop_gain_q + 6'h01;
          step_cnt_d = ramp_len(DECAY_STEP_CYC, tim_q.gain_rise_time);
        end else begin
          st_d = ST_HOLD;
          step_cnt_d = 32'(ATTACK_STEP_CYC);
        end
      end else begin
        st_d = ST_TRACK;
        step_cnt_d = 32'(ATTACK_STEP_CYC);
      end
    end
  end

  // gain change waits for a zero crossing only when the loop bit asks for it
  assign pending = loop_gain_q != app_gain_q;
  assign apply = !gate_q.loop_zero_cross_enable || zero_cross
    || (zc_cnt_q == 32'h0000_0000);

  // control registers; the record gain register is frozen while the loop runs
  always_ff @(posedge CORE_CLK or negedge RESETN) begin
    if (!RESETN) begin
      tim_q <= RST_LOOP_TIMING;
      gate_q <= RST_LOOP_GATE;
      rgain_q <= RST_RECORD_GAIN;
      REG_RDATA <= 16'h0000;
    end else begin
      if (REG_WR && sel_tim) tim_q <= REG_WDATA;
      if (REG_WR && sel_gate) gate_q <= REG_WDATA & MASK_LOOP_GATE;
      if (REG_WR && sel_gain && !loop_on) rgain_q <= REG_WDATA;
      if (REG_RD) REG_RDATA <= rd_mux;
    end
  end

  // loop state and step timer
  always_ff @(posedge CORE_CLK or negedge RESETN) begin
    if (!RESETN) begin
      st_q <= ST_TRACK;
      loop_gain_q <= 6'h00;
      step_cnt_q <= 32'h0000_0000;
    end else begin
      st_q <= st_d;
      loop_gain_q <= loop_gain_d;
      step_cnt_q <= step_cnt_d;
    end
  end

  // hold timer rearms while the loop is off and on any step that is not a quiet-free
  // drop below target, so the first rise after enabling still waits out the hold
  always_ff @(posedge CORE_CLK or negedge RESETN) begin
    if (!RESETN) begin
      hold_cnt_q <= 32'h0000_0000;
    end else if (!loop_on || (tick && !(below && !gate_on))) begin
      hold_cnt_q <= hold_len;
    end else if (!hold_done) begin
      hold_cnt_q <= hold_cnt_q - 32'h0000_0001;
    end
  end

  // applied gain and zero-cross timeout
  always_ff @(posedge CORE_CLK or negedge RESETN) begin
    if (!RESETN) begin
      app_gain_q <= 6'h00;
      zc_cnt_q <= 32'h0000_0000;
    end else if (!loop_on) begin
      app_gain_q <= loop_gain_d;
      zc_cnt_q <= zc_len;
    end else if (!pending) begin
      zc_cnt_q <= zc_len;
    end else if (apply) begin
      app_gain_q <= loop_gain_q;
      zc_cnt_q <= zc_len;
    end else begin
      zc_cnt_q <= zc_cnt_q - 32'h0000_0001;
    end
  end

  // amplifier outputs: steered channels take the loop gain in the extended range
  always_ff @(posedge CORE_CLK or negedge RESETN) begin
    if (!RESETN) begin
      PGA_LEFT <= '0;
      PGA_RIGHT <= '0;
      GATE_ENGAGED <= 1'b0;
    end else begin
      PGA_LEFT.gain <= ctl_l ? app_gain_q : rgain_q.record_volume_left;
      PGA_RIGHT.gain <= ctl_r ? app_gain_q : rgain_q.record_volume_right;
      PGA_LEFT.ext_range <= ctl_l || rgain_q.range_left;
      PGA_RIGHT.ext_range <= ctl_r || rgain_q.range_right;
      PGA_LEFT.mute <= rgain_q.mute
        || (ctl_l && gate_on && gate_q.quiet_gate_type);
      PGA_RIGHT.mute <= rgain_q.mute
        || (ctl_r && gate_on && gate_q.quiet_gate_type);
      GATE_ENGAGED <= gate_on;
    end
  end

endmodule

// ==== src/rlc_pkg.sv ====
// rlc_pkg: shared constants, register layouts and states of the record level loop.
// Assumes a 25 MHz core clock and 16-bit two's complement record converter samples.
package rlc_pkg;

  // clock period, used to turn printed times into cycle counts
  localparam int unsigned CLK_PERIOD_NS = 40;

  // register addresses on the codec control port
  localparam logic [6:0] ADDR_RECORD_GAIN = 7'h1C;
  localparam logic [6:0] ADDR_LOOP_TIMING = 7'h60;
  localparam logic [6:0] ADDR_LOOP_GATE = 7'h62;

  // reset values and writable bits
  localparam logic [15:0] RST_RECORD_GAIN = 16'h8000;
  localparam logic [15:0] RST_LOOP_TIMING = 16'hB032;
  localparam logic [15:0] RST_LOOP_GATE = 16'h3E00;
  localparam logic [15:0] MASK_LOOP_GATE = 16'hFFBF;

  // printed times; ramps are spread over the codes that span 90% of the range
  localparam int unsigned HOLD_BASE_NS = 2670000;
  localparam int unsigned DECAY_BASE_NS = 24000000;
  localparam int unsigned ATTACK_BASE_NS = 6000000;
  localparam int unsigned RAMP_CODES = 57;
  localparam int unsigned ZERO_CROSSING_WAIT_LIMIT_MIN_CYC = 16384;
  localparam int unsigned HOLD_BASE_CYC = (HOLD_BASE_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam int unsigned DECAY_STEP_CYC =
    (DECAY_BASE_NS + RAMP_CODES * CLK_PERIOD_NS - 1) / (RAMP_CODES * CLK_PERIOD_NS);
  localparam int unsigned ATTACK_STEP_CYC =
    (ATTACK_BASE_NS + RAMP_CODES * CLK_PERIOD_NS - 1) / (RAMP_CODES * CLK_PERIOD_NS);
  localparam logic [3:0] RAMP_CODE_MAX = 4'hA;

  // level scale: 8 units per octave (about 0.75 dB), full scale at 120
  localparam logic [6:0] TARGET_BASE_LOG = 7'h52;
  localparam logic [9:0] GATE_BASE_LOG = 10'h012;
  localparam logic [9:0] BOOST_LOG = 10'h01B;
  localparam logic [9:0] GAIN_ZERO_DB_CODE = 10'h017;
  localparam logic [14:0] LIMIT_LEVEL = 15'h7000;
  localparam logic [14:0] MAG_MAX = 15'h7FFF;

  // gain ceiling: code 7 plus 8 codes (6 dB) per field step
  localparam logic [5:0] CEIL_BASE_CODE = 6'h07;
  localparam logic [5:0] GAIN_MAX_CODE = 6'h3F;

  // loop channel select encodings
  localparam logic [1:0] SEL_OFF = 2'h0;

  typedef struct packed {
    logic [3:0] level_loop_target;
    logic [3:0] gain_rise_hold_delay;
    logic [3:0] gain_rise_time;
    logic [3:0] gain_fall_time;
  } rlc_timing_t;

  typedef struct packed {
    logic [1:0] level_loop_channel_select;
    logic [2:0] loop_gain_ceiling;
    logic [1:0] zero_crossing_wait_limit;
    logic loop_zero_cross_enable;
    logic quiet_gate_enable;
    logic reserved;
    logic quiet_gate_type;
    logic [4:0] quiet_gate_threshold;
  } rlc_gate_t;

  typedef struct packed {
    logic mute;
    logic range_left;
    logic [5:0] record_volume_left;
    logic record_zero_cross_enable;
    logic range_right;
    logic [5:0] record_volume_right;
  } rlc_rgain_t;

  typedef struct packed {
    logic [5:0] gain;
    logic ext_range;
    logic mute;
  } rlc_pga_t;

  typedef enum logic [1:0] {
    ST_TRACK = 2'b00,
    ST_HOLD = 2'b01,
    ST_RISE = 2'b11,
    ST_FALL = 2'b10
  } rlc_state_t;

  // magnitude of a sample, the most negative code clamped to full scale
  function automatic logic [14:0] rlc_mag(input logic [15:0] s);
    logic [15:0] neg;
    neg = -s;
    if (!s[15]) return s[14:0];
    if (neg[15]) return MAG_MAX;
    return neg[14:0];
  endfunction

endpackage

// ==== src/rlc_level_meter.sv ====
// rlc_level_meter: peak detector and zero-cross detector on the record converter output.
// Assumes samples arrive with a one-cycle valid strobe; clear comes from the loop's step tick.
`timescale 1ns/1ps
module rlc_level_meter
  import rlc_pkg::*;
(
  // clock and reset
  input wire logic clk,
  input wire logic rst_n,
  // samples
  input wire logic sample_valid,
  input wire logic [15:0] sample_left,
  input wire logic [15:0] sample_right,
  // control
  input wire logic use_left,
  input wire logic use_right,
  input wire logic clear,
  // results
  output logic [6:0] peak_log_q,
  output logic over_limit_q,
  output logic zero_cross_q
);

  logic [14:0] peak_q;
  logic [14:0] peak_d;
  logic over_q;
  logic sign_q;
  logic [14:0] mag_l;
  logic [14:0] mag_r;
  logic [14:0] mag_sel;
  logic sign_sel;

  // octave plus three mantissa bits: a cheap log with roughly 0.75 dB resolution
  function automatic logic [6:0] level_log(input logic [14:0] mag);
    logic [3:0] pos;
    logic [17:0] ext;
    pos = 4'h0;
    ext = {mag, 3'b000};
    for (int i = 0; i < 15; i++) begin
      if (mag[i]) pos = 4'(i);
    end
    level_log = {pos, ext[pos +: 3]};
  endfunction

  // larger of the watched channels; the unwatched one reads as silence
  assign mag_l = use_left ? rlc_mag(sample_left) : 15'h0000;
  assign mag_r = use_right ? rlc_mag(sample_right) : 15'h0000;
  assign mag_sel = (mag_l > mag_r) ? mag_l : mag_r;
  assign sign_sel = use_left ? sample_left[15] : sample_right[15];

  // a new sample in the clearing cycle still counts toward the next window
  always_comb begin
    peak_d = clear ? 15'h0000 : peak_q;
    if (sample_valid && mag_sel > peak_d) peak_d = mag_sel;
  end

  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      peak_q <= 15'h0000;
      over_q <= 1'b0;
      sign_q <= 1'b0;
      peak_log_q <= 7'h00;
      over_limit_q <= 1'b0;
      zero_cross_q <= 1'b0;
    end else begin
      peak_q <= peak_d;
      over_q <= (sample_valid && mag_sel >= LIMIT_LEVEL) || (over_q && !clear);
      sign_q <= sample_valid ? sign_sel : sign_q;
      peak_log_q <= level_log(peak_q);
      over_limit_q <= over_q;
      zero_cross_q <= sample_valid && (sign_sel != sign_q);
    end
  end

endmodule

// ==== verif/rlc_level_loop_sva.sv ====
// rlc_level_loop_sva: port-level properties of the record level loop.
// Assumes it is bound to rlc_level_loop and sees only that module's ports.
`timescale 1ns/1ps
module rlc_level_loop_sva
  import rlc_pkg::*;
(
  // clock and reset
  input wire logic CORE_CLK,
  input wire logic RESETN,
  // register port
  input wire logic REG_WR,
  input wire logic REG_RD,
  input wire logic [6:0] REG_ADDR,
  input wire logic [15:0] REG_WDATA,
  input wire logic [15:0] REG_RDATA,
  // amplifier controls
  input wire rlc_pkg::rlc_pga_t PGA_LEFT,
  input wire rlc_pkg::rlc_pga_t PGA_RIGHT,
  input wire logic GATE_ENGAGED
);
  logic [1:0] sel_q;
  logic gate_en_q;
  logic gate_mute_q;
  logic [15:0] rg_q;
  wire wr_gate = REG_WR && (REG_ADDR == ADDR_LOOP_GATE);
  wire wr_gain = REG_WR && (REG_ADDR == ADDR_RECORD_GAIN) && (sel_q == SEL_OFF);

  // shadow only the fields that decide what the outputs may do
  always_ff @(posedge CORE_CLK or negedge RESETN) begin
    if (!RESETN) begin
      sel_q <= 2'h0;
      gate_en_q <= 1'b0;
      gate_mute_q <= 1'b0;
      rg_q <= 16'h8000;
    end else begin
      if (wr_gate) begin
        sel_q <= REG_WDATA[15:14];
        gate_en_q <= REG_WDATA[7];
        gate_mute_q <= REG_WDATA[5];
      end
      if (wr_gain) begin
        rg_q <= REG_WDATA;
      end
    end
  end

  default clocking cb @(posedge CORE_CLK); endclocking
  default disable iff (!RESETN);

  // six quiet cycles cover the apply and output register stages
  sequence s_mode(logic [1:0] m);
    (sel_q == m && !wr_gain)[*6];
  endsequence
  // a select change may legally swap a channel between register and loop gain
  sequence s_on;
    (sel_q != SEL_OFF && !wr_gate)[*6];
  endsequence
  sequence s_gate_idle;
    (!gate_en_q || sel_q == SEL_OFF)[*4];
  endsequence
  sequence s_muting;
    (GATE_ENGAGED && gate_mute_q && sel_q == 2'h3)[*3];
  endsequence

  property p_rd_gain;
    REG_RD && !REG_WR && REG_ADDR == ADDR_RECORD_GAIN |=> REG_RDATA == $past(rg_q);
  endproperty
  property p_rd_sel;
    REG_RD && !REG_WR && REG_ADDR == ADDR_LOOP_GATE
      |=> REG_RDATA[15:14] == $past(sel_q) && !REG_RDATA[6];
  endproperty
  property p_off_follow;
    s_mode(SEL_OFF) |-> PGA_LEFT == {rg_q[13:8], rg_q[14], rg_q[15]}
      && PGA_RIGHT == {rg_q[5:0], rg_q[6], rg_q[15]};
  endproperty
  property p_keep_left;
    s_mode(2'h1) |-> PGA_LEFT.gain == rg_q[13:8];
  endproperty
  property p_keep_right;
    s_mode(2'h2) |-> PGA_RIGHT.gain == rg_q[5:0];
  endproperty
  property p_both_equal;
    s_mode(2'h3) |-> PGA_LEFT.gain == PGA_RIGHT.gain;
  endproperty
  property p_ext_range;
    s_on |-> (!sel_q[0] || PGA_RIGHT.ext_range) && (!sel_q[1] || PGA_LEFT.ext_range);
  endproperty
  property p_step;
    s_on |-> (6'(PGA_LEFT.gain - $past(PGA_LEFT.gain)) inside {6'h00, 6'h01, 6'h3F})
      && (6'(PGA_RIGHT.gain - $past(PGA_RIGHT.gain)) inside {6'h00, 6'h01, 6'h3F});
  endproperty
  property p_gate_off;
    s_gate_idle |-> !GATE_ENGAGED;
  endproperty
  property p_gate_mute;
    s_muting |-> PGA_LEFT.mute && PGA_RIGHT.mute;
  endproperty

  a_rd_gain: assert property (p_rd_gain)
    else $error("record gain register changed while the loop ran");
  a_rd_sel: assert property (p_rd_sel)
    else $error("loop select read back wrong");
  a_off_follow: assert property (p_off_follow)
    else $error("amplifiers do not follow the gain register with the loop off");
  a_keep_left: assert property (p_keep_left)
    else $error("left amplifier moved while only the right is steered");
  a_keep_right: assert property (p_keep_right)
    else $error("right amplifier moved while only the left is steered");
  a_both_equal: assert property (p_both_equal)
    else $error("stereo loop gains differ");
  a_ext_range: assert property (p_ext_range)
    else $error("steered amplifier not in extended range");
  a_step: assert property (p_step)
    else $error("loop gain moved by more than one code");
  a_gate_off: assert property (p_gate_off)
    else $error("gate engaged while disabled or loop off");
  a_gate_mute: assert property (p_gate_mute)
    else $error("engaged muting gate did not mute");
endmodule

bind rlc_level_loop rlc_level_loop_sva u_sva (
  .CORE_CLK(CORE_CLK), .RESETN(RESETN), .REG_WR(REG_WR), .REG_RD(REG_RD),
  .REG_ADDR(REG_ADDR), .REG_WDATA(REG_WDATA), .REG_RDATA(REG_RDATA),
  .PGA_LEFT(PGA_LEFT), .PGA_RIGHT(PGA_RIGHT), .GATE_ENGAGED(GATE_ENGAGED));

// ==== verif/rlc_adc_src.sv ====
// rlc_adc_src: stand-in for the record converter, one stereo sample every fourth cycle.
// Assumes the bench sets the amplitude; the sign flips each sample so zero crossings occur.
`timescale 1ns/1ps
module rlc_adc_src (
  // clock and reset
  input wire logic clk,
  input wire logic rst_n,
  // amplitude from the bench
  input wire logic [15:0] amp,
  // sample stream
  output logic valid,
  output logic [15:0] left,
  output logic [15:0] right
);
  logic [1:0] div_q;
  logic sign_q;

  // between strobes the lines invert every cycle, so nothing can lean on stale data
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      div_q <= 2'h0;
      sign_q <= 1'b0;
      valid <= 1'b0;
      left <= 16'h0000;
      right <= 16'h0000;
    end else begin
      div_q <= div_q + 2'h1;
      valid <= (div_q == 2'h3);
      if (div_q == 2'h3) begin
        sign_q <= ~sign_q;
        left <= sign_q ? -amp : amp;
        right <= sign_q ? -amp : amp;
      end else begin
        left <= ~left;
        right <= ~right;
      end
    end
  end
endmodule

// ==== verif/rlc_level_loop_tb_top.sv ====
// rlc_level_loop_tb_top: self-checking bench for the record level loop.
// Assumes the short timing parameters below; the converter model supplies samples.
`timescale 1ns/1ps
`define CHK(g, e) begin check_count++; if ((g) !== (e)) begin miscompares++; \
  $display("ERROR t=%0t got=%h exp=%h", $time, (g), (e)); end end
module rlc_level_loop_tb_top;
  import rlc_pkg::*;
  logic clk = 1'b0;
  logic rst_n = 1'b0;
  logic reg_wr = 1'b0;
  logic reg_rd = 1'b0;
  logic [6:0] reg_addr = 7'h00;
  logic [15:0] reg_wdata = 16'h0000;
  logic [15:0] rdata;
  logic mic_boost = 1'b0;
  logic [15:0] amp = 16'h0000;
  logic adc_valid;
  logic [15:0] adc_left;
  logic [15:0] adc_right;
  rlc_pga_t pga_l;
  rlc_pga_t pga_r;
  logic gate;
  int seed = 26;
  int miscompares = 0;
  int check_count = 0;

  rlc_level_loop #(.HOLD_BASE_CYC(20), .DECAY_STEP_CYC(16), .ATTACK_STEP_CYC(8),
    .ZERO_CROSSING_WAIT_LIMIT_MIN_CYC(32)) u_dut (
    .CORE_CLK(clk), .RESETN(rst_n), .REG_WR(reg_wr), .REG_RD(reg_rd),
    .REG_ADDR(reg_addr), .REG_WDATA(reg_wdata), .REG_RDATA(rdata),
    .ADC_VALID(adc_valid), .ADC_LEFT(adc_left), .ADC_RIGHT(adc_right),
    .MIC_BOOST(mic_boost), .PGA_LEFT(pga_l), .PGA_RIGHT(pga_r), .GATE_ENGAGED(gate));

  rlc_adc_src u_src (.clk(clk), .rst_n(rst_n), .amp(amp), .valid(adc_valid),
    .left(adc_left), .right(adc_right));

  // 25 MHz core clock
  always #20 clk = ~clk;

  // one register write; strobe drops one edge later
  task automatic wr(input logic [6:0] a, input logic [15:0] d);
    @(posedge clk);
    reg_wr <= 1'b1;
    reg_addr <= a;
    reg_wdata <= d;
    @(posedge clk);
    reg_wr <= 1'b0;
  endtask

  // one register read; data lands on the edge that sees the strobe
  task automatic rd(input logic [6:0] a, output logic [15:0] d);
    @(posedge clk);
    reg_rd <= 1'b1;
    reg_addr <= a;
    @(posedge clk);
    reg_rd <= 1'b0;
    #1 d = rdata;
  endtask

  task automatic wait_cyc(input int n);
    repeat (n) @(posedge clk);
    #1;
  endtask

  // manual amplifier setting expected from a gain register word
  function automatic rlc_pga_t exp_pga(input logic [15:0] rg, input logic right);
    return right ? {rg[5:0], rg[6], rg[15]} : {rg[13:8], rg[14], rg[15]};
  endfunction

  // loud sample just above the limiter threshold, randomised in its low bits
  function automatic logic [15:0] big_amp();
    return 16'h7400 + 16'($random(seed) & 32'h3FF);
  endfunction

  task automatic end_sim();
    $display("checks %0d mismatches %0d", check_count, miscompares);
    if (miscompares == 0 && check_count > 0) begin
      $display("NO MISMATCHES");
    end else begin
      $display("MISMATCHES SEEN");
    end
    $finish;
  endtask

  // a hang costs a mismatch; the whole run needs about 3250 cycles
  initial begin
    repeat (20000) @(posedge clk);
    miscompares++;
    end_sim();
  end

  initial begin
    logic [15:0] d;
    logic [15:0] rg;
    logic [5:0] g;
    repeat (6) @(posedge clk);
    rst_n <= 1'b1;
    mic_boost <= 1'($random(seed));
    rd(ADDR_LOOP_TIMING, d);
    `CHK(d, 16'hB032)
    rd(ADDR_LOOP_GATE, d);
    `CHK(d, 16'h3E00)
    // random manual settings with the loop off
    for (int i = 0; i < 4; i++) begin
      rg = 16'($random(seed));
      wr(ADDR_RECORD_GAIN, rg);
      wait_cyc(6);
      `CHK(pga_l, exp_pga(rg, 1'b0))
      `CHK(pga_r, exp_pga(rg, 1'b1))
    end
    wr(ADDR_LOOP_GATE, 16'h3E40);
    rd(ADDR_LOOP_GATE, d);
    `CHK(d, 16'h3E00)
    // quiet input: hold code 6 delays the rise, ceiling 000 caps it at code 7
    wr(ADDR_RECORD_GAIN, 16'h4040);
    wr(ADDR_LOOP_TIMING, 16'hB600);
    amp <= 16'h0100;
    wr(ADDR_LOOP_GATE, 16'hC000);
    wait_cyc(300);
    `CHK(pga_l.gain, 6'h00)
    wait_cyc(1500);
    `CHK(pga_l.gain, 6'h07)
    `CHK(pga_r.gain, 6'h07)
    amp <= big_amp();
    wait_cyc(100);
    `CHK(pga_l.gain < 6'h07, 1'b1)
    // slowest attack: only the limiter can pull gain down quickly
    wr(ADDR_LOOP_GATE, 16'h0000);
    wr(ADDR_RECORD_GAIN, 16'h6868);
    wr(ADDR_LOOP_TIMING, 16'hB03A);
    amp <= big_amp();
    wr(ADDR_LOOP_GATE, 16'hF800);
    wait_cyc(150);
    `CHK(pga_l.gain < 6'h1E, 1'b1)
    amp <= 16'h4000;
    g = pga_l.gain;
    wait_cyc(300);
    `CHK((g - pga_l.gain) <= 2, 1'b1)
    wr(ADDR_RECORD_GAIN, 16'h0000);
    rd(ADDR_RECORD_GAIN, d);
    `CHK(d, 16'h6868)
    // one channel steered, the other keeps its register volume
    wr(ADDR_LOOP_TIMING, 16'hB000);
    for (int s = 1; s <= 2; s++) begin
      wr(ADDR_LOOP_GATE, 16'h0000);
      amp <= big_amp();
      // zero-cross gated updates with the shortest timeout
      wr(ADDR_LOOP_GATE, {2'(s), 14'h3900});
      wait_cyc(200);
      `CHK((s == 1 ? pga_r.gain : pga_l.gain) < 6'h28, 1'b1)
      `CHK((s == 1 ? pga_l : pga_r), exp_pga(16'h6868, s == 2))
    end
    // silence with the gate on: muting type, then holding type
    amp <= 16'h0000;
    wr(ADDR_LOOP_GATE, 16'hF8BF);
    wait_cyc(100);
    `CHK(gate, 1'b1)
    `CHK({pga_l.mute, pga_r.mute}, 2'b11)
    wr(ADDR_LOOP_GATE, 16'hF89F);
    g = pga_l.gain;
    wait_cyc(300);
    `CHK(pga_l.mute, 1'b0)
    `CHK(pga_l.gain, g)
    wr(ADDR_LOOP_GATE, 16'h00BF);
    wait_cyc(10);
    `CHK(gate, 1'b0)
    end_sim();
  end
endmodule
